// file: design/pms_phase_mode_selector.sv
// Phase count and operating mode selection with ripple pulse generation
//
// How it works
// - Deep sleep low and hint high run all selected phases.
// - Full phase operation drives selected phases interleaved, fixed frequency.
// - Hint low or deep sleep high, without override, runs phase 1 only.
// - Multi-phase switching events come from the master clock.
// - Single phase from hint low uses ripple mode, continuous conduction only.
// - Single phase from deep sleep uses ripple mode with diode emulation control.
// - Transient, sleep change or current limit forces full phase continuous mode.
// - Transient window starts on any code change or sleep entry and exit.
// - Transient window length comes from a timer of about 100 us.
// - Per-phase frequency is master clock over the active phase count.
// - Master clock slows as the voltage code falls.
// - Ripple mode sets phase 1 when error level reaches the code limit.
// - Ripple ramp rises while phase 1 is high; reset when it meets error level.
// - Phase count detected in first three oscillator cycles after enable.
// - Phases found pulled high stay high impedance; others drive normally.
module pms_phase_mode_selector #(
  parameter int MASK_CYCLES = pms_pkg::MASK_CYCLES,
  parameter int DIV_WIDTH = pms_pkg::DIV_WIDTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic low_power_hint_n_in,
  input wire logic deep_sleep_request_in,
  input wire logic current_limit_in,
  input wire logic [pms_pkg::CODE_WIDTH-1:0] voltage_code_in,
  input wire logic [pms_pkg::LEVEL_WIDTH-1:0] error_level_in,
  input wire logic [pms_pkg::LEVEL_WIDTH-1:0] rpm_offset_in,
  input wire logic [pms_pkg::LEVEL_WIDTH-1:0] ramp_slope_in,
  input wire logic phase2_drive_in,
  input wire logic phase3_drive_in,
  output logic phase1_drive_out,
  output logic phase2_drive_out,
  output logic phase2_drive_oe_n_out,
  output logic phase3_drive_out,
  output logic phase3_drive_oe_n_out,
  output logic discontinuous_ctl_n_out,
  output logic ripple_pulse_mode_out,
  output logic transient_out,
  output logic [1:0] active_phases_out
);
  localparam int LW = pms_pkg::LEVEL_WIDTH;
  localparam int TW = $clog2(MASK_CYCLES + 1);

  // ==========================================
  // Synchronisers for pins
  logic [1:0] hint_sync_reg;
  logic [1:0] sleep_sync_reg;
  logic [1:0] ilim_sync_reg;
  logic [1:0] p2_sync_reg;
  logic [1:0] p3_sync_reg;
  logic [1:0] en_sync_reg;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hint_sync_reg <= 2'h3;
      sleep_sync_reg <= 2'h0;
      ilim_sync_reg <= 2'h0;
      p2_sync_reg <= 2'h0;
      p3_sync_reg <= 2'h0;
      en_sync_reg <= 2'h0;
    end
    else
    begin
      hint_sync_reg <= {hint_sync_reg[0], low_power_hint_n_in};
      sleep_sync_reg <= {sleep_sync_reg[0], deep_sleep_request_in};
      ilim_sync_reg <= {ilim_sync_reg[0], current_limit_in};
      p2_sync_reg <= {p2_sync_reg[0], phase2_drive_in};
      p3_sync_reg <= {p3_sync_reg[0], phase3_drive_in};
      en_sync_reg <= {en_sync_reg[0], enable_in};
    end
  end
  wire hint_n = hint_sync_reg[1];
  wire sleep = sleep_sync_reg[1];
  wire ilim = ilim_sync_reg[1];
  wire enabled = en_sync_reg[1];

  // ==========================================
  // Master clock: period shrinks as code rises
  logic [DIV_WIDTH-1:0] div_cnt_reg;
  logic [DIV_WIDTH-1:0] div_top;
  logic tick;
  // Invert at code width first so the widening adds zeros, not ones
  assign div_top = DIV_WIDTH'(pms_pkg::DIV_AT_TOP)
    + DIV_WIDTH'(pms_pkg::CODE_WIDTH'(~voltage_code_in));
  assign tick = (div_cnt_reg == '0);
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      div_cnt_reg <= '0;
    else if (tick)
      div_cnt_reg <= div_top;
    else
      div_cnt_reg <= div_cnt_reg - 1'b1;
  end

  // ==========================================
  // Phase detection over three master cycles
  pms_pkg::pms_state_e state_reg;
  logic [1:0] det_cnt_reg;
  logic [1:0] user_phases_reg;
  logic p2_off_reg;
  logic p3_off_reg;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg <= pms_pkg::PMS_DETECT;
      det_cnt_reg <= 2'h0;
      p2_off_reg <= 1'b0;
      p3_off_reg <= 1'b0;
      user_phases_reg <= 2'h3;
    end
    else if (!enabled)
    begin
      state_reg <= pms_pkg::PMS_DETECT;
      det_cnt_reg <= 2'h0;
    end
    else
    begin
      case (state_reg)
        pms_pkg::PMS_DETECT:
        begin
          if (tick)
          begin
            det_cnt_reg <= det_cnt_reg + 2'h1;
            if (det_cnt_reg == 2'(pms_pkg::DETECT_CYCLES - 1))
            begin
              state_reg <= pms_pkg::PMS_RUN;
              p2_off_reg <= p2_sync_reg[1];
              p3_off_reg <= p3_sync_reg[1];
              user_phases_reg <= p2_sync_reg[1] ? 2'h1 : (p3_sync_reg[1] ? 2'h2 : 2'h3);
            end
          end
        end
        pms_pkg::PMS_RUN: state_reg <= pms_pkg::PMS_RUN;
        default: state_reg <= pms_pkg::PMS_DETECT;
      endcase
    end
  end
  wire running = (state_reg == pms_pkg::PMS_RUN) && enabled;

  // ==========================================
  // Transient window timer
  logic [pms_pkg::CODE_WIDTH-1:0] code_prev_reg;
  logic sleep_prev_reg;
  logic [TW-1:0] mask_cnt_reg;
  wire trans_start = (code_prev_reg != voltage_code_in) || (sleep_prev_reg != sleep);
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      code_prev_reg <= '0;
      sleep_prev_reg <= 1'b0;
      mask_cnt_reg <= '0;
    end
    else
    begin
      code_prev_reg <= voltage_code_in;
      sleep_prev_reg <= sleep;
      if (trans_start)
        mask_cnt_reg <= TW'(MASK_CYCLES);
      else if (mask_cnt_reg != '0)
        mask_cnt_reg <= mask_cnt_reg - 1'b1;
    end
  end
  wire in_transient = (mask_cnt_reg != '0) || trans_start;

  // ==========================================
  // Mode decision, applied only on cycle boundaries
  pms_pkg::pms_mode_e mode_reg;
  pms_pkg::pms_mode_e mode_next;
  logic boundary;
  logic [2:0] drive_reg;
  always_comb
  begin
    if (in_transient || ilim)
      mode_next = pms_pkg::PMS_FULL_PWM;
    else if (sleep)
      mode_next = pms_pkg::PMS_RPM_AUTO;
    else if (!hint_n)
      mode_next = pms_pkg::PMS_RPM_CCM;
    else
      mode_next = pms_pkg::PMS_FULL_PWM;
  end
  assign boundary = !phase1_drive_out && !phase2_drive_out && !phase3_drive_out;
  // Load only with every drive idle; a real switch holds back the pulse start of that edge
  wire mode_load = boundary && (drive_reg == 3'h0)
    && (tick || mode_reg != pms_pkg::PMS_FULL_PWM);
  wire mode_switch = mode_load && (mode_next != mode_reg);
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      mode_reg <= pms_pkg::PMS_FULL_PWM;
    else if (mode_load)
      mode_reg <= mode_next;
  end
  wire ripple_pulse_mode = (mode_reg != pms_pkg::PMS_FULL_PWM);

  // ==========================================
  // Interleaved PWM: one phase per master tick
  logic [1:0] slot_reg;
  logic [LW-1:0] pwm_ramp_reg;
  logic [1:0] active;
  assign active = ripple_pulse_mode ? 2'h1 : user_phases_reg;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      slot_reg <= 2'h0;
    else if (ripple_pulse_mode || !running)
      slot_reg <= 2'h0;
    else if (tick)
      slot_reg <= (slot_reg + 2'h1 >= active) ? 2'h0 : slot_reg + 2'h1;
  end

  // ==========================================
  // Ramp shared by PWM on-time and ripple mode
  logic [LW-1:0] rpm_limit;
  assign rpm_limit = LW'({voltage_code_in, 3'h0}) + rpm_offset_in;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      drive_reg <= 3'h0;
      pwm_ramp_reg <= '0;
    end
    else if (!running)
    begin
      drive_reg <= 3'h0;
      pwm_ramp_reg <= '0;
    end
    else if (ripple_pulse_mode)
    begin
      drive_reg[2:1] <= 2'h0;
      if (!drive_reg[0] && error_level_in >= rpm_limit && !mode_switch)
      begin
        drive_reg[0] <= 1'b1;
        pwm_ramp_reg <= '0;
      end
      else if (drive_reg[0] && pwm_ramp_reg >= error_level_in)
        drive_reg[0] <= 1'b0;
      else if (drive_reg[0])
        pwm_ramp_reg <= pwm_ramp_reg + ramp_slope_in;
    end
    else if (tick && pwm_ramp_reg == '0 && !mode_switch)
    begin
      drive_reg <= 3'h1 << slot_reg;
      pwm_ramp_reg <= ramp_slope_in;
    end
    else if (|drive_reg && pwm_ramp_reg >= error_level_in)
    begin
      drive_reg <= 3'h0;
      pwm_ramp_reg <= '0;
    end
    else if (|drive_reg)
      pwm_ramp_reg <= pwm_ramp_reg + ramp_slope_in;
  end

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase1_drive_out <= 1'b0;
      phase2_drive_out <= 1'b0;
      phase3_drive_out <= 1'b0;
      phase2_drive_oe_n_out <= 1'b1;
      phase3_drive_oe_n_out <= 1'b1;
      discontinuous_ctl_n_out <= 1'b1;
      ripple_pulse_mode_out <= 1'b0;
      transient_out <= 1'b0;
      active_phases_out <= 2'h0;
    end
    else
    begin
      phase1_drive_out <= drive_reg[0];
      phase2_drive_out <= drive_reg[1];
      phase3_drive_out <= drive_reg[2];
      phase2_drive_oe_n_out <= !running || p2_off_reg;
      phase3_drive_oe_n_out <= !running || p3_off_reg;
      discontinuous_ctl_n_out <= !(mode_reg == pms_pkg::PMS_RPM_AUTO);
      ripple_pulse_mode_out <= ripple_pulse_mode;
      transient_out <= in_transient;
      active_phases_out <= running ? active : 2'h0;
    end
  end

  // ==========================================
  // Checks
  single_phase_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ripple_pulse_mode |-> !drive_reg[1] && !drive_reg[2]) else $error("extra phase in ripple mode");
  auto_dcm_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode_reg == pms_pkg::PMS_RPM_AUTO) |=> !discontinuous_ctl_n_out)
    else $error("diode emulation not enabled");
  ccm_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode_reg == pms_pkg::PMS_RPM_CCM) |=> discontinuous_ctl_n_out)
    else $error("diode emulation in ccm mode");
  force_full_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_transient || ilim) && mode_load |=> mode_reg == pms_pkg::PMS_FULL_PWM)
    else $error("override ignored");
  window_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
    trans_start |=> mask_cnt_reg == TW'(MASK_CYCLES)) else $error("window not loaded");
  window_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !trans_start && mask_cnt_reg != '0 |=> mask_cnt_reg == $past(mask_cnt_reg) - 1'b1)
    else $error("window not counting");
  boundary_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
    mode_reg != $past(mode_reg) |-> $past(mode_load)) else $error("mode changed mid pulse");
  full_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !in_transient && !ilim && !sleep && hint_n |-> mode_next == pms_pkg::PMS_FULL_PWM)
    else $error("full phase not chosen");
  hiz_a: assert property (@(posedge clk_in) disable iff (rst_in)
    running && p3_off_reg |=> phase3_drive_oe_n_out) else $error("disabled phase driven");
  rpm_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    running && ripple_pulse_mode && !mode_switch && !drive_reg[0] && error_level_in >= rpm_limit
    |=> drive_reg[0])
    else $error("ripple pulse not set");
  rpm_clr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    running && ripple_pulse_mode && drive_reg[0] && pwm_ramp_reg >= error_level_in |=> !drive_reg[0])
    else $error("ripple pulse not reset");
  slot_a: assert property (@(posedge clk_in) disable iff (rst_in)
    slot_reg != 2'h0 |-> slot_reg < active || ripple_pulse_mode) else $error("slot beyond phases");
  pwm_tick_a: assert property (@(posedge clk_in) disable iff (rst_in)
    running && !ripple_pulse_mode && !$past(ripple_pulse_mode) && $rose(|drive_reg) |-> $past(tick))
    else $error("pwm start off clock");
  detect_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(state_reg == pms_pkg::PMS_RUN) |-> $past(det_cnt_reg) == 2'h2)
    else $error("detect length wrong");
  clock_slow_a: assert property (@(posedge clk_in) disable iff (rst_in)
    tick |=> div_cnt_reg == $past(div_top)) else $error("clock period not loaded");
endmodule // pms_phase_mode_selector

// file: design/pms_pkg.sv
// Package of constants and types for the phase and mode selector
package pms_pkg;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MASK_TIME_US = 100;
  localparam int MASK_CYCLES = (MASK_TIME_US * 1000) / CLK_PERIOD_NS;
  // ==========================================
  // Master clock divider and phase detection
  localparam int DIV_WIDTH = 8;
  localparam logic [7:0] DIV_AT_TOP = 8'h7f; // Lowest divider, top voltage code
  localparam int DETECT_CYCLES = 3;
  // ==========================================
  // Widths
  localparam int CODE_WIDTH = 7;
  localparam int LEVEL_WIDTH = 10;
  // ==========================================
  // Operating modes
  typedef enum logic [1:0] {
    PMS_FULL_PWM,
    PMS_RPM_CCM,
    PMS_RPM_AUTO
  } pms_mode_e;
  typedef enum logic [1:0] {
    PMS_DETECT,
    PMS_RUN
  } pms_state_e;
endpackage : pms_pkg

// file: verification/pms_pin_model.sv
// Far-side model of the phase 2 and phase 3 pins: strap pull-ups and gate driver inputs
module pms_pin_model (
  input wire logic strap2_in,
  input wire logic strap3_in,
  input wire logic drive2_in,
  input wire logic oe2_n_in,
  input wire logic drive3_in,
  input wire logic oe3_n_in,
  output logic pin2_out,
  output logic pin3_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pin level: device drive when enabled, else the strap input level, high for a pull-up strap
  assign pin2_out = !oe2_n_in ? drive2_in : strap2_in;
  assign pin3_out = !oe3_n_in ? drive3_in : strap3_in;
endmodule // pms_pin_model

// file: verification/tb_top.sv
// Self-checking bench for the phase and mode selector
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Signals and model state
  localparam int MASK = 50;
  logic clk_in, rst_in, en, hint_n, dsr, cl, pin2, pin3, st2, st3;
  logic d1, d2, d3, oe2, oe3, disc_n, rip_mode, trans;
  logic [6:0] code;
  logic [9:0] err, off, slope;
  logic [1:0] act;
  logic [2:0] dv;
  logic [2:0] prev = 3'h0;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 32'he865_cd37;
  int now_c = 0;
  int hi_w = 0;
  int last_w = 0;
  int q_ph[$];
  int q_t[$];
  assign dv = {d3, d2, d1};

  // ==========================================
  // Design, far side and clock
  pms_phase_mode_selector #(.MASK_CYCLES(MASK)) i_pms_phase_mode_selector (
    .clk_in(clk_in), .rst_in(rst_in), .enable_in(en), .low_power_hint_n_in(hint_n),
    .deep_sleep_request_in(dsr), .current_limit_in(cl), .voltage_code_in(code),
    .error_level_in(err), .rpm_offset_in(off), .ramp_slope_in(slope),
    .phase2_drive_in(pin2), .phase3_drive_in(pin3), .phase1_drive_out(d1),
    .phase2_drive_out(d2), .phase2_drive_oe_n_out(oe2), .phase3_drive_out(d3),
    .phase3_drive_oe_n_out(oe3), .discontinuous_ctl_n_out(disc_n),
    .ripple_pulse_mode_out(rip_mode), .transient_out(trans), .active_phases_out(act));
  pms_pin_model i_pms_pin_model (.strap2_in(st2), .strap3_in(st3), .drive2_in(d2),
    .oe2_n_in(oe2), .drive3_in(d3), .oe3_n_in(oe3), .pin2_out(pin2), .pin3_out(pin3));
  // Free-running 100 MHz clock
  initial
  begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end
  // Log rising drive edges with their cycle, and the phase 1 pulse width
  always @(negedge clk_in)
  begin
    now_c++;
    for (int k = 0; k < 3; k++)
      if (dv[k] === 1'h1 && prev[k] === 1'h0)
      begin
        q_ph.push_back(k + 1);
        q_t.push_back(now_c);
      end
    if (dv[0] === 1'h1) hi_w++;
    else if (prev[0] === 1'h1)
    begin
      last_w = hi_w;
      hi_w = 0;
    end
    prev = dv;
  end

  // ==========================================
  // Helpers
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  task automatic chk(input string nm, input int e, input logic [15:0] g);
    checks_done++;
    if (g !== 16'(e))
    begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  // Every hint, sleep and limit combination against the mode table
  task automatic modes(input int n);
    logic full, od;
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      od = dsr;
      {hint_n, dsr, cl} <= 3'(i);
      cyc(6);
      @(negedge clk_in);
      if (dsr !== od) chk("sleep_window", 1, 16'(trans));
      cyc(450);
      @(negedge clk_in);
      full = cl | (hint_n & !dsr);
      chk("ripple_mode", !full, 16'(rip_mode));
      chk("disc_ctl_n", !(!full && dsr), 16'(disc_n));
      chk("active", full ? n : 1, 16'(act));
      chk("window_over", 0, 16'(trans));
    end
  endtask
  // Interleave order and per-phase period for random voltage codes
  task automatic freq(input int n);
    int p;
    for (int r = 0; r < 2; r++)
    begin
      cyc(1);
      {hint_n, dsr, cl} <= 3'h4;
      code <= 7'($random(seed));
      err <= 10'h028;
      cyc(500);
      q_ph.delete();
      q_t.delete();
      for (int k = 0; k < 3000 && q_t.size() <= n; k++) cyc(1);
      @(negedge clk_in);
      p = 255 - int'(code);
      chk("enough_rises", 1, 16'(q_t.size() > n));
      if (q_t.size() > n)
      begin
        chk("phase_period", n * p, 16'(q_t[n] - q_t[0]));
        for (int k = 0; k < n; k++)
          chk("phase_order", q_ph[k] % n + 1, 16'(q_ph[k + 1]));
      end
    end
  endtask
  // Ripple pulses, forced full mode in the window, window length
  task automatic ripple();
    int w;
    w = 0;
    cyc(1);
    {hint_n, dsr, cl} <= 3'h0;
    code <= 7'h01;
    err <= 10'h01e;
    cyc(600);
    q_ph.delete();
    cyc(200);
    @(negedge clk_in);
    chk("ripple_pulses", 1, 16'(q_ph.size() > 2));
    chk("phase1_only", q_ph.size(), 16'(q_ph.sum()));
    chk("pulse_width", 1, 16'(last_w >= 3 && last_w <= 4));
    cyc(1);
    err <= 10'h000;
    cyc(20);
    code <= 7'h02;
    for (int k = 0; k < 200; k++)
    begin
      @(negedge clk_in);
      w += int'(trans === 1'h1);
      if (k == 10) chk("forced_full", 0, 16'(rip_mode));
    end
    chk("window_len", 1, 16'(w >= MASK && w <= MASK + 2));
    cyc(1);
    err <= 10'h011; // One step below the limit for code 2 with offset 2
    cyc(99);
    q_ph.delete();
    cyc(200);
    @(negedge clk_in);
    chk("below_limit", 0, 16'(q_ph.size()));
  endtask

  // ==========================================
  // Main sequence over the three strap settings
  initial
  begin
    {rst_in, en, hint_n, dsr, cl, st2, st3} = 7'h48;
    code = 7'h7f;
    err = 10'h000;
    off = 10'h002;
    slope = 10'h00a;
    for (int n = 3; n > 0; n--)
    begin
      cyc(1);
      {st2, st3} <= {n == 1, n < 3};
      {rst_in, en, hint_n, dsr, cl} <= 5'h14;
      code <= 7'h7f;
      cyc(4);
      rst_in <= 1'h0;
      cyc(2);
      en <= 1'h1;
      cyc(700);
      @(negedge clk_in);
      chk("detected", n, 16'(act));
      chk("oe2_n", n < 2, 16'(oe2));
      chk("oe3_n", n < 3, 16'(oe3));
      modes(n);
      freq(n);
      ripple();
    end
    conclude();
  end
  // Watchdog against a hang: about twice the expected run of some 23,000 cycles
  initial
  begin
    #500_000;
    error_cnt++;
    conclude();
  end
endmodule // tb_top
